// *** core/qos_arb_pkg.sv ***
// Constants shared by the quality-of-service arbiter and its rate regulator.
// Assumes one 50 MHz clock, an active-low asynchronous reset and a plain register port.
// Notes on behaviour
// - Every request carries a four-bit priority; larger value means higher priority.
// - A port set static uses its programmed priority, ignoring request priority.
// - Grant the pending request with the numerically largest priority.
// - Among equal priorities grant the least recently granted requester.
// - All four bits used in arbitration; DRAM port gets only top bit.
// - DRAM urgency chosen from priority bit, control bit or fabric input.
// - After reset static mode is off: each port uses its request priority, and ties go to port 0 first.
// - Regulator limits outstanding count, peak, average and burst issue rates.
// - Regulation applies to processor, coherency, DMA and AHB master requests.
// - Priorities and regulator settings are programmed through the register port.
package qos_arb_pkg;
	localparam int NUM_PORTS = 6;
	localparam int PORT_W = 3;
	localparam int QOS_W = 4;
	localparam int QOS_MSB = 3;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CNT_W = 16;
	localparam int OUT_W = 8;
	// Port numbering
	localparam logic [PORT_W-1:0] PORT_CPU = 3'h0;
	localparam logic [PORT_W-1:0] PORT_COHERENT = 3'h1;
	localparam logic [PORT_W-1:0] PORT_DMA = 3'h2;
	localparam logic [PORT_W-1:0] PORT_AHB = 3'h3;
	localparam logic [PORT_W-1:0] PORT_FABRIC0 = 3'h4;
	localparam logic [PORT_W-1:0] PORT_FABRIC1 = 3'h5;
	// Register offsets
	localparam logic [ADDR_W-1:0] REG_STATIC_EN = 8'h00;
	localparam logic [ADDR_W-1:0] REG_STATIC_PRIO = 8'h04;
	localparam logic [ADDR_W-1:0] REG_URGENT_SEL = 8'h08;
	localparam logic [ADDR_W-1:0] REG_REG_EN = 8'h0c;
	localparam logic [ADDR_W-1:0] REG_GRANT_STAT = 8'h10;
	localparam logic [ADDR_W-1:0] REG_RATE_BASE = 8'h20;
	localparam logic [ADDR_W-1:0] REG_RATE_STRIDE = 8'h10;
	// Per-regulator sub-offsets: max outstanding, peak gap, average gap, burst credit
	localparam logic [ADDR_W-1:0] RATE_MAX_OUT = 8'h00;
	localparam logic [ADDR_W-1:0] RATE_PEAK = 8'h04;
	localparam logic [ADDR_W-1:0] RATE_AVG = 8'h08;
	localparam logic [ADDR_W-1:0] RATE_BURST = 8'h0c;
	localparam int NUM_REGULATED = 4;
	// Urgency source select codes
	localparam logic [1:0] URG_FROM_QOS = 2'h0;
	localparam logic [1:0] URG_FROM_CTRL = 2'h1;
	localparam logic [1:0] URG_FROM_FABRIC = 2'h2;
	// Reset values
	localparam logic [DATA_W-1:0] STATIC_PRIO_RST = 32'h0000_0000;
	localparam logic [OUT_W-1:0] MAX_OUT_RST = 8'hff;
	localparam logic [CNT_W-1:0] GAP_RST = 16'h0000;
	localparam logic [CNT_W-1:0] BURST_RST = 16'h0001;
endpackage : qos_arb_pkg

// *** core/qos_interconnect_arbiter.sv ***
// Two-level arbiter for one shared slave: priority first, then least recent grant.
// Assumes requesters hold req until granted; done pulses mark completed transactions.
`timescale 1ns/1ps
module qos_interconnect_arbiter (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Requests from masters
	input wire logic [qos_arb_pkg::NUM_PORTS-1:0] req_i,
	input wire logic [qos_arb_pkg::NUM_PORTS*qos_arb_pkg::QOS_W-1:0] req_qos_i,
	input wire logic [qos_arb_pkg::NUM_PORTS-1:0] done_i,
	// Grant towards slave
	output logic [qos_arb_pkg::NUM_PORTS-1:0] grant_o,
	output logic grant_valid_o,
	output logic [qos_arb_pkg::PORT_W-1:0] grant_port_o,
	output logic [qos_arb_pkg::QOS_W-1:0] grant_qos_o,
	// DRAM port urgency
	input wire logic fabric_dram_urgency_input_i,
	output logic dram_urgent_o,
	// Register port
	input wire logic [qos_arb_pkg::ADDR_W-1:0] addr_i,
	input wire logic [qos_arb_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [qos_arb_pkg::DATA_W-1:0] rdata_o
);
	localparam int N = qos_arb_pkg::NUM_PORTS;
	localparam int QW = qos_arb_pkg::QOS_W;
	localparam int R = qos_arb_pkg::NUM_REGULATED;

	// Configuration registers
	logic [N-1:0] static_en_q;
	logic [N*QW-1:0] static_prio_q;
	logic [1:0] urgent_sel_q;
	logic urgent_ctrl_q;
	logic [R-1:0] reg_en_q;
	logic [qos_arb_pkg::OUT_W-1:0] max_out_q [R];
	logic [qos_arb_pkg::CNT_W-1:0] peak_q [R];
	logic [qos_arb_pkg::CNT_W-1:0] avg_q [R];
	logic [qos_arb_pkg::CNT_W-1:0] burst_q [R];
	logic [qos_arb_pkg::DATA_W-1:0] rdata_q, rdata_d;

	// Fabric urgency pin synchroniser
	logic urg_meta_q, urg_sync_q;

	// Arbitration state: age counter per port, larger means waited longer
	logic [QW-1:0] age_q [N];
	logic [N-1:0] grant_q;
	logic grant_valid_q;
	logic [qos_arb_pkg::PORT_W-1:0] grant_port_q;
	logic [QW-1:0] grant_qos_q;
	logic dram_urgent_q;

	// Decoded effective priority and eligibility
	logic [QW-1:0] eff_qos [N];
	logic [N-1:0] eligible;
	logic [R-1:0] allow;
	logic [N-1:0] sel_d;
	logic any_d;
	logic [qos_arb_pkg::PORT_W-1:0] port_d;
	logic [QW-1:0] best_qos;
	logic [QW-1:0] best_age;
	logic urgent_d;

	// Register write decode
	wire logic wr_static_en = wr_i && (addr_i == qos_arb_pkg::REG_STATIC_EN);
	wire logic wr_static_prio = wr_i && (addr_i == qos_arb_pkg::REG_STATIC_PRIO);
	wire logic wr_urgent = wr_i && (addr_i == qos_arb_pkg::REG_URGENT_SEL);
	wire logic wr_reg_en = wr_i && (addr_i == qos_arb_pkg::REG_REG_EN);
	wire logic [qos_arb_pkg::ADDR_W-1:0] rate_off = addr_i - qos_arb_pkg::REG_RATE_BASE;
	wire logic rate_hit = (addr_i >= qos_arb_pkg::REG_RATE_BASE)
		&& (rate_off < qos_arb_pkg::ADDR_W'(R) * qos_arb_pkg::REG_RATE_STRIDE);
	wire logic [1:0] rate_idx = rate_off[5:4];
	wire logic [qos_arb_pkg::ADDR_W-1:0] rate_sub = {4'h0, rate_off[3:0]};

	// Effective priority: static setting overrides request field
	generate
		for (genvar p = 0; p < N; p++) begin : g_prio
			assign eff_qos[p] = static_en_q[p] ? static_prio_q[p*QW +: QW]
				: req_qos_i[p*QW +: QW];
		end
		// Regulators sit on processor, coherency, DMA and AHB ports only
		for (genvar r = 0; r < R; r++) begin : g_reg
			rate_regulator u_reg (
				.clk_i(clk_i),
				.rst_n_i(rst_n_i),
				.enable_i(reg_en_q[r]),
				.max_out_i(max_out_q[r]),
				.peak_gap_i(peak_q[r]),
				.avg_gap_i(avg_q[r]),
				.burst_i(burst_q[r]),
				.issue_i(grant_q[r]),
				.done_i(done_i[r]),
				.allow_o(allow[r])
			);
			assign eligible[r] = req_i[r] && allow[r] && !grant_q[r];
		end
		for (genvar f = R; f < N; f++) begin : g_free
			assign eligible[f] = req_i[f] && !grant_q[f];
		end
	endgenerate

	// Winner search: highest priority, then oldest grant among equals
	always_comb begin
		sel_d = '0;
		any_d = 1'b0;
		port_d = '0;
		best_qos = '0;
		best_age = '0;
		for (int p = 0; p < N; p++) begin
			if (eligible[p] && (!any_d || eff_qos[p] > best_qos
				|| (eff_qos[p] == best_qos && age_q[p] > best_age))) begin
				any_d = 1'b1;
				port_d = qos_arb_pkg::PORT_W'(p);
				best_qos = eff_qos[p];
				best_age = age_q[p];
			end
		end
		if (any_d) begin
			sel_d[port_d] = 1'b1;
		end
	end

	// Urgency source selection for the DRAM port
	always_comb begin
		unique case (urgent_sel_q)
			qos_arb_pkg::URG_FROM_QOS: urgent_d = any_d && best_qos[qos_arb_pkg::QOS_MSB];
			qos_arb_pkg::URG_FROM_CTRL: urgent_d = urgent_ctrl_q;
			qos_arb_pkg::URG_FROM_FABRIC: urgent_d = urg_sync_q;
			default: urgent_d = 1'b0;
		endcase
	end

	// Fabric urgency pin, two flops
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			urg_meta_q <= 1'b0;
			urg_sync_q <= 1'b0;
		end else begin
			urg_meta_q <= fabric_dram_urgency_input_i;
			urg_sync_q <= urg_meta_q;
		end
	end

	// Grant outputs register the winner
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			grant_q <= '0;
			grant_valid_q <= 1'b0;
			grant_port_q <= '0;
			grant_qos_q <= '0;
			dram_urgent_q <= 1'b0;
		end else begin
			grant_q <= sel_d;
			grant_valid_q <= any_d;
			grant_port_q <= port_d;
			grant_qos_q <= best_qos;
			dram_urgent_q <= urgent_d;
		end
	end

	// Least recent order: winner resets to zero, every other port ages in a cycle with a grant, saturating
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int p = 0; p < N; p++) begin
				age_q[p] <= '0;
			end
		end else begin
			for (int p = 0; p < N; p++) begin
				if (sel_d[p]) begin
					age_q[p] <= '0;
				end else if (any_d && age_q[p] != '1) begin
					age_q[p] <= age_q[p] + 1'b1;
				end
			end
		end
	end

	// Control registers; reset turns static mode off on every port
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			static_en_q <= '0;
			static_prio_q <= qos_arb_pkg::STATIC_PRIO_RST[N*QW-1:0];
			urgent_sel_q <= qos_arb_pkg::URG_FROM_QOS;
			urgent_ctrl_q <= 1'b0;
			reg_en_q <= '0;
		end else begin
			if (wr_static_en) begin
				static_en_q <= wdata_i[N-1:0];
			end
			if (wr_static_prio) begin
				static_prio_q <= wdata_i[N*QW-1:0];
			end
			if (wr_urgent) begin
				urgent_sel_q <= wdata_i[1:0];
				urgent_ctrl_q <= wdata_i[4];
			end
			if (wr_reg_en) begin
				reg_en_q <= wdata_i[R-1:0];
			end
		end
	end

	// Regulator setting registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int r = 0; r < R; r++) begin
				max_out_q[r] <= qos_arb_pkg::MAX_OUT_RST;
				peak_q[r] <= qos_arb_pkg::GAP_RST;
				avg_q[r] <= qos_arb_pkg::GAP_RST;
				burst_q[r] <= qos_arb_pkg::BURST_RST;
			end
		end else if (wr_i && rate_hit) begin
			unique case (rate_sub)
				qos_arb_pkg::RATE_MAX_OUT: max_out_q[rate_idx] <= wdata_i[qos_arb_pkg::OUT_W-1:0];
				qos_arb_pkg::RATE_PEAK: peak_q[rate_idx] <= wdata_i[qos_arb_pkg::CNT_W-1:0];
				qos_arb_pkg::RATE_AVG: avg_q[rate_idx] <= wdata_i[qos_arb_pkg::CNT_W-1:0];
				qos_arb_pkg::RATE_BURST: burst_q[rate_idx] <= wdata_i[qos_arb_pkg::CNT_W-1:0];
				default: ;
			endcase
		end
	end

	// Read mux, zero for unmapped addresses
	always_comb begin
		rdata_d = '0;
		if (addr_i == qos_arb_pkg::REG_STATIC_EN) begin
			rdata_d[N-1:0] = static_en_q;
		end else if (addr_i == qos_arb_pkg::REG_STATIC_PRIO) begin
			rdata_d[N*QW-1:0] = static_prio_q;
		end else if (addr_i == qos_arb_pkg::REG_URGENT_SEL) begin
			rdata_d[1:0] = urgent_sel_q;
			rdata_d[4] = urgent_ctrl_q;
		end else if (addr_i == qos_arb_pkg::REG_REG_EN) begin
			rdata_d[R-1:0] = reg_en_q;
		end else if (addr_i == qos_arb_pkg::REG_GRANT_STAT) begin
			rdata_d[qos_arb_pkg::PORT_W-1:0] = grant_port_q;
			rdata_d[8 +: QW] = grant_qos_q;
			rdata_d[16] = grant_valid_q;
			rdata_d[17] = dram_urgent_q;
			rdata_d[24 +: R] = allow;
		end else if (rate_hit) begin
			if (rate_sub == qos_arb_pkg::RATE_MAX_OUT) begin
				rdata_d[qos_arb_pkg::OUT_W-1:0] = max_out_q[rate_idx];
			end else if (rate_sub == qos_arb_pkg::RATE_PEAK) begin
				rdata_d[qos_arb_pkg::CNT_W-1:0] = peak_q[rate_idx];
			end else if (rate_sub == qos_arb_pkg::RATE_AVG) begin
				rdata_d[qos_arb_pkg::CNT_W-1:0] = avg_q[rate_idx];
			end else if (rate_sub == qos_arb_pkg::RATE_BURST) begin
				rdata_d[qos_arb_pkg::CNT_W-1:0] = burst_q[rate_idx];
			end
		end
	end

	// Read data stands in the cycle after the strobe only
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rd_i ? rdata_d : '0;
		end
	end

	assign grant_o = grant_q;
	assign grant_valid_o = grant_valid_q;
	assign grant_port_o = grant_port_q;
	assign grant_qos_o = grant_qos_q;
	assign dram_urgent_o = dram_urgent_q;
	assign rdata_o = rdata_q;
endmodule : qos_interconnect_arbiter

// *** core/rate_regulator.sv ***
// Rate regulator for one master: outstanding limit, peak gap, average gap with burst credit.
// Assumes issue and complete pulses come from logic on the same clock.
`timescale 1ns/1ps
module rate_regulator (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Settings
	input wire logic enable_i,
	input wire logic [qos_arb_pkg::OUT_W-1:0] max_out_i,
	input wire logic [qos_arb_pkg::CNT_W-1:0] peak_gap_i,
	input wire logic [qos_arb_pkg::CNT_W-1:0] avg_gap_i,
	input wire logic [qos_arb_pkg::CNT_W-1:0] burst_i,
	// Traffic events
	input wire logic issue_i,
	input wire logic done_i,
	// Permission
	output logic allow_o
);
	logic [qos_arb_pkg::OUT_W-1:0] out_q, out_d;
	logic [qos_arb_pkg::CNT_W-1:0] peak_q, peak_d;
	logic [qos_arb_pkg::CNT_W-1:0] avg_q, avg_d;
	logic [qos_arb_pkg::CNT_W-1:0] credit_q, credit_d;
	wire logic out_ok;
	wire logic peak_ok;
	wire logic credit_ok;
	wire logic avg_tick;
	wire logic credit_full;

	// Limit checks; each is waived when regulation is off
	assign out_ok = (out_q < max_out_i);
	assign peak_ok = (peak_q == '0);
	assign credit_ok = (credit_q != '0);
	assign allow_o = !enable_i || (out_ok && peak_ok && credit_ok);
	assign avg_tick = (avg_q == '0);
	assign credit_full = (credit_q >= burst_i);

	// Next values for the counters
	assign out_d = out_q + qos_arb_pkg::OUT_W'(issue_i) - qos_arb_pkg::OUT_W'(done_i && out_q != '0);
	assign peak_d = issue_i ? peak_gap_i : (peak_q != '0 ? peak_q - 1'b1 : peak_q);
	assign avg_d = avg_tick ? avg_gap_i : avg_q - 1'b1;
	// Average gap refills one credit; burst caps the pool
	assign credit_d = (enable_i ? credit_q - qos_arb_pkg::CNT_W'(issue_i && credit_ok) : credit_q)
		+ qos_arb_pkg::CNT_W'(avg_tick && !credit_full);

	// Counter state
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			out_q <= '0;
			peak_q <= '0;
			avg_q <= '0;
			credit_q <= qos_arb_pkg::BURST_RST;
		end else begin
			out_q <= out_d;
			peak_q <= peak_d;
			avg_q <= avg_d;
			credit_q <= credit_d;
		end
	end
endmodule : rate_regulator

// *** tb/master_model.sv ***
// Masters on the request side: each request is held until granted.
// Assumes the bench steers go, qos and slow; done follows a grant by 1 or 4 cycles.
`timescale 1ns/1ps
module master_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Bench controls
	input wire logic [5:0] go_i,
	input wire logic [23:0] qos_i,
	input wire logic slow_i,
	// Arbiter side
	input wire logic [5:0] grant_i,
	output logic [5:0] req_o,
	output logic [23:0] req_qos_o,
	output logic [5:0] done_o
);
	logic [23:0] sh_q;
	// Completion comes promptly or late
	assign done_o = slow_i ? sh_q[23:18] : sh_q[5:0];
	// Request held until granted, then dropped for a cycle
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			req_o <= '0;
			req_qos_o <= '0;
			sh_q <= '0;
		end else begin
			req_o <= (req_o | go_i) & ~grant_i;
			sh_q <= {sh_q[17:0], grant_i};
			for (int p = 0; p < 6; p++) begin
				if (!req_o[p]) req_qos_o[4*p +: 4] <= qos_i[4*p +: 4];
			end
		end
	end
endmodule : master_model

// *** tb/qos_arb_chk.sv ***
// Checker on the arbiter ports: grant shape, priority source, urgency, read timing.
// Assumes it is bound onto the arbiter and shares its clock and reset.
`timescale 1ns/1ps
module qos_arb_chk (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Requests
	input wire logic [5:0] req_i,
	input wire logic [23:0] req_qos_i,
	input wire logic [5:0] done_i,
	// Grants
	input wire logic [5:0] grant_o,
	input wire logic grant_valid_o,
	input wire logic [2:0] grant_port_o,
	input wire logic [3:0] grant_qos_o,
	// Urgency
	input wire logic fabric_dram_urgency_input_i,
	input wire logic dram_urgent_o,
	// Register port
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	logic [5:0] sten_q;
	logic [23:0] stpr_q;
	logic [2:0] cfg_q;
	// Shadow of static and urgency settings
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sten_q <= '0;
			stpr_q <= '0;
			cfg_q <= '0;
		end else if (wr_i) begin
			if (addr_i == qos_arb_pkg::REG_STATIC_EN) sten_q <= wdata_i[5:0];
			if (addr_i == qos_arb_pkg::REG_STATIC_PRIO) stpr_q <= wdata_i[23:0];
			if (addr_i == qos_arb_pkg::REG_URGENT_SEL) cfg_q <= {wdata_i[4], wdata_i[1:0]};
		end
	end
	// Pin selected one and three cycles back, at the two ends of the synchroniser span
	sequence s_pin_path;
		$past(cfg_q[1:0]) == 2'h2 && $past(cfg_q[1:0], 3) == 2'h2;
	endsequence
	a_grant_onehot: assert property ($onehot0(grant_o))
		else $error("more than one grant");
	a_valid_flag: assert property (grant_valid_o == (grant_o != 6'h00))
		else $error("grant valid mismatch");
	a_port_index: assert property (grant_valid_o |-> grant_o == (6'h01 << grant_port_o))
		else $error("grant port mismatch");
	a_grant_had_req: assert property (grant_valid_o |-> ($past(req_i) & grant_o) != 6'h00)
		else $error("grant without request");
	a_no_repeat: assert property (grant_valid_o |=> (grant_o & $past(grant_o)) == 6'h00)
		else $error("same port granted twice in a row");
	a_dyn_prio: assert property (grant_valid_o && ($past(sten_q) & grant_o) == 6'h00
		|-> grant_qos_o == 4'($past(req_qos_i) >> (4 * grant_port_o))) else $error("dynamic qos");
	a_static_prio: assert property (grant_valid_o && ($past(sten_q) & grant_o) != 6'h00
		|-> grant_qos_o == 4'($past(stpr_q) >> (4 * grant_port_o))) else $error("static qos");
	a_read_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
		else $error("read data outside its cycle");
	a_urg_msb: assert property ($past(cfg_q[1:0]) == 2'h0 && grant_valid_o
		|-> dram_urgent_o == grant_qos_o[3]) else $error("urgency not top bit");
	a_urg_ctrl: assert property ($past(cfg_q[1:0]) == 2'h1 |-> dram_urgent_o == $past(cfg_q[2]))
		else $error("urgency not control bit");
	a_urg_pin: assert property (s_pin_path |-> dram_urgent_o == $past(fabric_dram_urgency_input_i, 3))
		else $error("urgency not fabric pin");
endmodule : qos_arb_chk
bind qos_interconnect_arbiter qos_arb_chk i_qos_arb_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.req_i(req_i), .req_qos_i(req_qos_i), .done_i(done_i), .grant_o(grant_o),
	.grant_valid_o(grant_valid_o), .grant_port_o(grant_port_o), .grant_qos_o(grant_qos_o),
	.fabric_dram_urgency_input_i(fabric_dram_urgency_input_i), .dram_urgent_o(dram_urgent_o),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));

// *** tb/test_qos_interconnect_arbiter.sv ***
// Bench for the arbiter: registers, priority, ties, static mode, urgency, regulators.
// Assumes the master model on the request side and the bound checker.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
	$display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module test_qos_interconnect_arbiter;
	logic clk_i;
	logic rst_n_i;
	logic [5:0] go, req, done, grant;
	logic [23:0] qos, req_qos;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	logic [2:0] gport;
	logic [3:0] gqos;
	logic slow, pin, wr, rd, gv, urg;
	int n_errors, n_tests;
	int cnt [6];
	logic [7:0] ra [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h80};
	logic [31:0] rv [9] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'hff, 32'h0, 32'h0, 32'h1, 32'h0};
	qos_interconnect_arbiter i_qos_interconnect_arbiter (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req), .req_qos_i(req_qos), .done_i(done),
		.grant_o(grant), .grant_valid_o(gv), .grant_port_o(gport), .grant_qos_o(gqos),
		.fabric_dram_urgency_input_i(pin), .dram_urgent_o(urg), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata));
	master_model i_master_model (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .go_i(go), .qos_i(qos), .slow_i(slow),
		.grant_i(grant), .req_o(req), .req_qos_o(req_qos), .done_o(done));
	// 50 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	// Lowest index among the highest priorities
	function automatic logic [2:0] best(input logic [5:0] m, input logic [23:0] q);
		logic [2:0] w;
		w = 3'h0;
		for (int p = 5; p >= 0; p--) begin
			if (m[p] && (!m[w] || q[4*p +: 4] >= q[4*w +: 4])) w = 3'(p);
		end
		return w;
	endfunction : best
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		#1;
		`CHK("read data", e, rdata)
	endtask : rd_chk
	// Looks only after a fresh edge, so a grant still showing from before is not taken
	task automatic wait_grant();
		int k;
		k = 0;
		do begin
			@(posedge clk_i);
			#1;
			k++;
		end while (gv !== 1'b1 && k < 40);
		`CHK("grant seen", 1'b1, gv)
	endtask : wait_grant
	// Drain, then one request burst
	task automatic pulse(input logic [5:0] m, input logic [23:0] q);
		repeat (5) @(posedge clk_i);
		qos <= q;
		go <= m;
		@(posedge clk_i);
		go <= '0;
		wait_grant();
	endtask : pulse
	task automatic wrap_up();
		if (n_errors == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : wrap_up
	// Watchdog
	initial begin
		#400000;
		n_errors++;
		wrap_up();
	end
	initial begin
		int a, b, gap, last, dn, ng;
		logic [3:0] qa, qb;
		logic [5:0] m;
		logic [23:0] q;
		{go, qos, slow, pin, wr, rd, addr, wdata} = '0;
		rst_n_i = 1'b0;
		void'($urandom(32'h7714));
		repeat (3) @(posedge clk_i);
		rst_n_i <= 1'b1;
		for (int i = 0; i < 9; i++) rd_chk(ra[i], rv[i]);
		// Two requesters with distinct random priorities
		for (int i = 0; i < 20; i++) begin
			a = $urandom % 6;
			b = (a + 1 + $urandom % 5) % 6;
			qa = 4'($urandom);
			qb = qa ^ 4'(1 + $urandom % 15);
			q = 24'($urandom);
			q[4*a +: 4] = qa;
			q[4*b +: 4] = qb;
			m = 6'(1 << a) | 6'(1 << b);
			pulse(m, q);
			`CHK("winner", best(m, q), gport)
			`CHK("winner qos", (qa > qb) ? qa : qb, gqos)
		end
		// Equal priorities on all ports share grants evenly
		cnt = '{6{0}};
		repeat (5) @(posedge clk_i);
		qos <= {6{4'h5}};
		go <= 6'h3f;
		wait_grant();
		for (int i = 0; i < 12; i++) begin
			`CHK("grant each cycle", 1'b1, gv)
			cnt[gport]++;
			@(posedge clk_i);
			#1;
		end
		go <= '0;
		for (int p = 0; p < 6; p++) `CHK("tie share", 2, cnt[p])
		// Static priority overrides the request priority
		wr_reg(8'h04, 32'h0000_0f00);
		rd_chk(8'h04, 32'h0000_0f00);
		for (int i = 0; i < 2; i++) begin
			wr_reg(8'h00, i ? 32'h0 : 32'h4);
			pulse(6'h24, 24'he0_0000);
			`CHK("static winner", i ? 3'h5 : 3'h2, gport)
			`CHK("static qos", i ? 4'he : 4'hf, gqos)
			// Status shows the loser, granted one cycle after the winner
			rd_chk(8'h10, i ? 32'h0f01_0002 : 32'h0f03_0e05);
		end
		// Urgency from control bit and fabric pin
		for (int i = 0; i < 4; i++) begin
			wr_reg(8'h08, i == 0 ? 32'h11 : (i == 1 ? 32'h1 : 32'h2));
			pin <= (i == 2);
			repeat (5) @(posedge clk_i);
			#1;
			`CHK("urgency", i[0] ? 1'b0 : 1'b1, urg)
		end
		wr_reg(8'h08, 32'h0);
		// Peak gap on regulated ports 0, 2 and 3, outstanding limit on port 1, average gap on port 3
		for (int r = 0; r < 4; r++) begin
			gap = (r == 1) ? 0 : 2 + r;
			wr_reg(8'(32'h24 + 16 * r), 32'(gap));
			wr_reg(8'(32'h20 + 16 * r), r == 1 ? 32'h1 : 32'hff);
			wr_reg(8'(32'h28 + 16 * r), r == 3 ? 32'hf : 32'h0);
			wr_reg(8'h0c, 32'(1 << r));
			slow <= (r == 1);
			go <= 6'(1 << r);
			last = 0;
			dn = 0;
			ng = 0;
			for (int c = 0; c < 60; c++) begin
				@(posedge clk_i);
				#1;
				if (grant[r] === 1'b1) begin
					if (ng > 0) `CHK("issue spacing", 1'b1, c - last > gap)
					if (ng > 0 && r == 1) `CHK("done first", 1'b1, dn > 0)
					if (ng > 1 && r == 3) `CHK("average spacing", 1'b1, c - last > 8)
					last = c;
					dn = 0;
					ng++;
				end
				if (done[r] === 1'b1) dn++;
			end
			`CHK("regulated grants", 1'b1, ng > 1)
			go <= '0;
			wr_reg(8'h0c, 32'h0);
		end
		// Random traffic under each urgency source
		wr_reg(8'h00, $urandom);
		wr_reg(8'h04, $urandom);
		for (int s = 0; s < 3; s++) begin
			wr_reg(8'h08, 32'(s) | ($urandom & 32'h10));
			repeat (100) begin
				@(posedge clk_i);
				go <= 6'($urandom);
				qos <= 24'($urandom);
				slow <= 1'($urandom);
				pin <= 1'($urandom);
			end
		end
		wrap_up();
	end
endmodule : test_qos_interconnect_arbiter
